// >>> hw/mmu_irq_pkg.sv
// Shared constants for the display and digitizer interrupt block
package mmu_irq_pkg;

  // ---------------------------------------------------------------
  // Register map, byte addresses of 32-bit words
  // ---------------------------------------------------------------
  localparam int          ADDR_W          = 5;
  localparam logic [4:0]  OFF_STATUS_MODE = 5'h00;
  localparam logic [4:0]  OFF_DIAG_A      = 5'h04;
  localparam logic [4:0]  OFF_DIAG_B      = 5'h08;
  localparam logic [4:0]  OFF_IRQ_STATUS  = 5'h0c;
  localparam logic [4:0]  OFF_IRQ_MASK    = 5'h10;

  // ---------------------------------------------------------------
  // Status and mode register fields
  // ---------------------------------------------------------------
  localparam int          SMR_W           = 16;
  localparam int          SMR_CLR_DISP    = 3;
  localparam int          SMR_CLR_DIG     = 4;
  localparam int          SMR_DISP_EN     = 9;
  localparam logic [15:0] SMR_RESET       = 16'h0000;
  localparam logic [15:0] SMR_DIAG_KEY    = 16'h007f;

  // ---------------------------------------------------------------
  // Diagnostic port codes
  // ---------------------------------------------------------------
  localparam int          DIAG_W          = 8;
  localparam logic [7:0]  DIAG_A_ENTER    = 8'h1a;
  localparam logic [7:0]  DIAG_B_ENTER    = 8'h04;
  localparam logic [7:0]  DIAG_B_LEAVE    = 8'h05;
  localparam logic [7:0]  DIAG_RESET      = 8'h00;

  // ---------------------------------------------------------------
  // Event status bits, shared by status and mask registers
  // ---------------------------------------------------------------
  localparam int          EV_W            = 3;
  localparam int          EV_DISP         = 0;
  localparam int          EV_DIG          = 1;
  localparam int          EV_DIAG         = 2;
  localparam logic [2:0]  EV_RESET        = 3'h0;

  // ---------------------------------------------------------------
  // Pin synchroniser
  // ---------------------------------------------------------------
  localparam int          PIN_W           = 3;
  localparam int          PIN_SEND_NEW    = 0;
  localparam int          PIN_DIG_REQ     = 1;
  localparam int          PIN_MSG_SEL     = 2;
  localparam logic [2:0]  PIN_IDLE        = 3'h3;

endpackage

// >>> hw/pin_sync_if.sv
// Carrier between the pin synchroniser and the interrupt logic
`timescale 1ns/1ps
interface pin_sync_if #(
  parameter int WIDTH = 3
);
  logic [WIDTH-1:0] raw;
  logic [WIDTH-1:0] level;

  modport filter (input raw, output level);
  modport user   (output raw, input level);
endinterface

// >>> hw/pin_sync.sv
// Three-stage synchroniser with agreement filter for external pins
`timescale 1ns/1ps
module pin_sync #(
  parameter int               WIDTH      = 3,
  parameter logic [WIDTH-1:0] IDLE_LEVEL = '1
) (
  input  wire logic clock_i,
  input  wire logic rst_i,
  pin_sync_if.filter pins
);

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;
    logic [WIDTH-1:0] level;
  } sync_state_t;

  localparam sync_state_t SYNC_RESET = '{IDLE_LEVEL, IDLE_LEVEL, IDLE_LEVEL, IDLE_LEVEL};

  sync_state_t s;
  sync_state_t next_s;

  // Stage one feeds only stage two; the filter looks at stages two and three
  always_comb begin
    next_s        = s;
    next_s.stage1 = pins.raw;
    next_s.stage2 = s.stage1;
    next_s.stage3 = s.stage2;
    for (int i = 0; i < WIDTH; i++) begin
      if (s.stage2[i] == s.stage3[i]) begin
        next_s.level[i] = s.stage3[i];
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      s <= SYNC_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign pins.level = s.level;

endmodule

// >>> hw/mmu_display_digitizer_irq.sv
// Display-cycle and digitizer-message interrupt requests with register slave
// Overview of operation
// [R1] Host enters diagnostics: 1a, 007f, then 4
// [R2] Host leaves diagnostics: 5 then 007f
// [R3] Enabled send-new pulse raises display request
// [R4] Clear bit 3 drops display request
// [R5] Digitizer pulse then select low raises request
// [R6] Clear bit 4 drops digitizer request
// [R7] Display request drives slave input zero
// [R8] Digitizer request drives slave input one
// [R9] Host unmasks both cascade levels to see requests
// [R10] Requests hold as levels until cleared
`timescale 1ns/1ps
module mmu_display_digitizer_irq (
  input  wire logic        clock_i,
  input  wire logic        rst_i,
  input  wire logic [4:0]  address_i,
  input  wire logic        read_i,
  input  wire logic        write_i,
  input  wire logic [31:0] writedata_i,
  input  wire logic [3:0]  byteenable_i,
  output logic      [31:0] readdata_o,
  output logic             waitrequest_o,
  input  wire logic        send_new_strobe_n_i,
  input  wire logic        digitizer_request_n_i,
  input  wire logic        message_select_i,
  output logic             slave_request_in0_o,
  output logic             slave_request_in1_o,
  output logic             diag_mode_o,
  output logic             irq_o
);

  // ---------------------------------------------------------------
  // Types and state
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    DIG_IDLE  = 3'b001,
    DIG_LOW   = 3'b010,
    DIG_ARMED = 3'b100
  } dig_state_t;

  typedef enum logic [4:0] {
    DIAG_NORMAL  = 5'b00001,
    DIAG_GOT_A   = 5'b00010,
    DIAG_GOT_KEY = 5'b00100,
    DIAG_ISOLATE = 5'b01000,
    DIAG_LEAVING = 5'b10000
  } diag_state_t;

  typedef struct packed {
    logic [15:0] status_mode_reg;
    logic [7:0]  diag_a;
    logic [7:0]  diag_b;
    logic [2:0]  status;
    logic [2:0]  mask;
    dig_state_t  dig;
    diag_state_t diag;
    logic        send_prev;
    logic        disp_irq;
    logic        dig_irq;
    logic        diag_out;
    logic        irq_out;
    logic        waitreq;
    logic [31:0] rdata;
  } irq_state_t;

  localparam irq_state_t STATE_RESET = '{
    status_mode_reg:       mmu_irq_pkg::SMR_RESET,
    diag_a:    mmu_irq_pkg::DIAG_RESET,
    diag_b:    mmu_irq_pkg::DIAG_RESET,
    status:    mmu_irq_pkg::EV_RESET,
    mask:      mmu_irq_pkg::EV_RESET,
    dig:       DIG_IDLE,
    diag:      DIAG_NORMAL,
    send_prev: 1'b1,
    disp_irq:  1'b0,
    dig_irq:   1'b0,
    diag_out:  1'b0,
    irq_out:   1'b0,
    waitreq:   1'b1,
    rdata:     32'h0000_0000
  };

  irq_state_t s;
  irq_state_t next_s;

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  pin_sync_if #(.WIDTH(mmu_irq_pkg::PIN_W)) pins ();

  assign pins.raw = {message_select_i, digitizer_request_n_i, send_new_strobe_n_i};

  pin_sync #(
    .WIDTH      (mmu_irq_pkg::PIN_W),
    .IDLE_LEVEL (mmu_irq_pkg::PIN_IDLE)
  ) u_pin_sync (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .pins    (pins)
  );

  logic send_lvl;
  logic dig_req_n;
  logic msg_sel;

  assign send_lvl  = pins.level[mmu_irq_pkg::PIN_SEND_NEW];
  assign dig_req_n = pins.level[mmu_irq_pkg::PIN_DIG_REQ];
  assign msg_sel   = pins.level[mmu_irq_pkg::PIN_MSG_SEL];

  // ---------------------------------------------------------------
  // Bus decode helpers
  // ---------------------------------------------------------------
  function automatic logic hit(input logic [4:0] addr, input logic [4:0] off);
    return addr[4:2] == off[4:2];
  endfunction

  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  logic        accept;
  logic        wr_acc;
  logic [31:0] wmask;
  logic [31:0] wdata;
  logic        smr_wr;
  logic        clr_disp;
  logic        clr_dig;
  logic        disp_raise;
  logic        dig_raise;
  logic [2:0]  rd_clr;
  logic [2:0]  events;
  logic [15:0] smr_wval;

  // A request is taken at the edge where waitrequest stands low
  assign accept   = (read_i | write_i) & ~s.waitreq;
  assign wr_acc   = accept & write_i;
  assign wmask    = lane_mask(byteenable_i);
  assign wdata    = writedata_i & wmask;
  assign smr_wr   = wr_acc & hit(address_i, mmu_irq_pkg::OFF_STATUS_MODE);
  assign smr_wval = (s.status_mode_reg & ~wmask[15:0]) | wdata[15:0];
  assign clr_disp = smr_wr & wdata[mmu_irq_pkg::SMR_CLR_DISP];             // [R4]
  assign clr_dig  = smr_wr & wdata[mmu_irq_pkg::SMR_CLR_DIG];              // [R6]

  // Enabled rising edge of the send-new strobe starts a write-display cycle
  assign disp_raise = send_lvl & ~s.send_prev & s.status_mode_reg[mmu_irq_pkg::SMR_DISP_EN]; // [R3]
  assign dig_raise  = (s.dig == DIG_ARMED) & dig_req_n & ~msg_sel;             // [R5]

  // Only bits already reported in the read data are cleared, so a late
  // event is never swallowed by the read that could not show it
  assign rd_clr = (accept & read_i & hit(address_i, mmu_irq_pkg::OFF_IRQ_STATUS))
                  ? s.rdata[2:0] : 3'h0;

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    next_s = s;
    events = 3'h0;

    // Bus handshake: one wait cycle, then a single low cycle
    next_s.waitreq = 1'b1;
    if ((read_i | write_i) && s.waitreq) begin
      next_s.waitreq = 1'b0;
      unique case (1'b1)
        hit(address_i, mmu_irq_pkg::OFF_STATUS_MODE): begin
          next_s.rdata = {16'h0000, s.status_mode_reg};
          next_s.rdata[mmu_irq_pkg::SMR_CLR_DISP] = s.disp_irq;
          next_s.rdata[mmu_irq_pkg::SMR_CLR_DIG]  = s.dig_irq;
        end
        hit(address_i, mmu_irq_pkg::OFF_DIAG_A):     next_s.rdata = {24'h000000, s.diag_a};
        hit(address_i, mmu_irq_pkg::OFF_DIAG_B):     next_s.rdata = {24'h000000, s.diag_b};
        hit(address_i, mmu_irq_pkg::OFF_IRQ_STATUS): next_s.rdata = {29'h0, s.status};
        hit(address_i, mmu_irq_pkg::OFF_IRQ_MASK):   next_s.rdata = {29'h0, s.mask};
        default:                                     next_s.rdata = 32'h0000_0000;
      endcase
    end

    // Register writes; the clear bits act as strobes and are not stored
    if (smr_wr) begin
      next_s.status_mode_reg = smr_wval;
      next_s.status_mode_reg[mmu_irq_pkg::SMR_CLR_DISP] = 1'b0;
      next_s.status_mode_reg[mmu_irq_pkg::SMR_CLR_DIG]  = 1'b0;
    end
    if (wr_acc && hit(address_i, mmu_irq_pkg::OFF_DIAG_A) && byteenable_i[0]) begin
      next_s.diag_a = wdata[7:0];
    end
    if (wr_acc && hit(address_i, mmu_irq_pkg::OFF_DIAG_B) && byteenable_i[0]) begin
      next_s.diag_b = wdata[7:0];
    end
    if (wr_acc && hit(address_i, mmu_irq_pkg::OFF_IRQ_MASK) && byteenable_i[0]) begin
      next_s.mask = wdata[2:0];
    end

    // Diagnostic-mode entry and exit sequence; a wrong entry step (mask writes aside) restarts entry, exit waits
    if (wr_acc && byteenable_i[0]) begin
      unique case (s.diag)
        DIAG_NORMAL: begin
          if (hit(address_i, mmu_irq_pkg::OFF_DIAG_A) &&
              wdata[7:0] == mmu_irq_pkg::DIAG_A_ENTER) begin                // [R1]
            next_s.diag = DIAG_GOT_A;
          end
        end
        DIAG_GOT_A: begin
          if (smr_wr) begin
            next_s.diag = (smr_wval == mmu_irq_pkg::SMR_DIAG_KEY) ? DIAG_GOT_KEY
                                                                   : DIAG_NORMAL;
          end else if (!hit(address_i, mmu_irq_pkg::OFF_IRQ_MASK)) begin
            next_s.diag = DIAG_NORMAL;
          end
        end
        DIAG_GOT_KEY: begin
          if (hit(address_i, mmu_irq_pkg::OFF_DIAG_B)) begin
            next_s.diag = (wdata[7:0] == mmu_irq_pkg::DIAG_B_ENTER) ? DIAG_ISOLATE
                                                                    : DIAG_NORMAL;
          end else if (!hit(address_i, mmu_irq_pkg::OFF_IRQ_MASK)) begin
            next_s.diag = DIAG_NORMAL;
          end
        end
        DIAG_ISOLATE: begin
          if (hit(address_i, mmu_irq_pkg::OFF_DIAG_B) &&
              wdata[7:0] == mmu_irq_pkg::DIAG_B_LEAVE) begin                // [R2]
            next_s.diag = DIAG_LEAVING;
          end
        end
        DIAG_LEAVING: begin
          if (smr_wr && smr_wval == mmu_irq_pkg::SMR_DIAG_KEY) begin          // [R2]
            next_s.diag = DIAG_NORMAL;
          end
        end
      endcase
    end
    next_s.diag_out = (next_s.diag == DIAG_ISOLATE) || (next_s.diag == DIAG_LEAVING);
    events[mmu_irq_pkg::EV_DIAG] = next_s.diag_out ^ s.diag_out;

    // End-of-digitizer-message handshake tracker
    unique case (s.dig)
      DIG_IDLE: begin
        if (!dig_req_n && msg_sel) begin
          next_s.dig = DIG_LOW;
        end
      end
      DIG_LOW: begin
        if (!msg_sel) begin
          next_s.dig = DIG_IDLE;
        end else if (dig_req_n) begin
          next_s.dig = DIG_ARMED;
        end
      end
      DIG_ARMED: begin
        if (dig_raise) begin
          next_s.dig = DIG_IDLE;                                             // [R5]
        end else if (!dig_req_n) begin
          next_s.dig = msg_sel ? DIG_LOW : DIG_IDLE;
        end
      end
    endcase

    // Requests are levels; a raise in the clearing cycle wins
    next_s.send_prev = send_lvl;
    next_s.disp_irq  = disp_raise | (s.disp_irq & ~clr_disp);               // [R3] [R4] [R10]
    next_s.dig_irq   = dig_raise | (s.dig_irq & ~clr_dig);                  // [R5] [R6] [R10]
    events[mmu_irq_pkg::EV_DISP] = disp_raise;
    events[mmu_irq_pkg::EV_DIG]  = dig_raise;

    next_s.status  = (s.status & ~rd_clr) | events;
    next_s.irq_out = |(next_s.status & next_s.mask);
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      s <= STATE_RESET;
    end else begin
      s <= next_s;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign readdata_o          = s.rdata;
  assign waitrequest_o       = s.waitreq;
  assign slave_request_in0_o = s.disp_irq;                                   // [R7]
  assign slave_request_in1_o = s.dig_irq;                                    // [R8]
  assign diag_mode_o         = s.diag_out;
  assign irq_o               = s.irq_out;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  logic irq_status_disp;
  assign irq_status_disp = s.status[mmu_irq_pkg::EV_DISP];

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  a_disp_raise: assert property (disp_raise |=> slave_request_in0_o && irq_status_disp) // [R3]
    else $error("display request not raised by enabled strobe");
  a_disp_clear: assert property (clr_disp && !disp_raise |=> !slave_request_in0_o) // [R4]
    else $error("display request not cleared by bit 3");
  a_dig_raise: assert property (dig_raise |=> slave_request_in1_o)            // [R5]
    else $error("digitizer request not raised after handshake");
  a_dig_clear: assert property (clr_dig && !dig_raise |=> !slave_request_in1_o) // [R6]
    else $error("digitizer request not cleared by bit 4");
  a_req0_cause: assert property ($rose(slave_request_in0_o) |-> $past(disp_raise)) // [R7]
    else $error("slave input zero rose without a display cycle");
  a_req1_cause: assert property ($rose(slave_request_in1_o) |-> $past(dig_raise)) // [R8]
    else $error("slave input one rose without a digitizer message");
  a_req_hold: assert property (slave_request_in0_o && !clr_disp |=> slave_request_in0_o) // [R10]
    else $error("display request dropped without clear");
  a_dig_hold: assert property ($fell(slave_request_in1_o) |-> $past(clr_dig)) // [R10]
    else $error("digitizer request dropped without clear");
  a_bus_answer: assert property ((read_i || write_i) && waitrequest_o
                                 |=> !waitrequest_o ##1 waitrequest_o)
    else $error("bus answer not exactly one cycle after wait");

  c_disp_cycle: cover property (disp_raise ##[1:20] clr_disp);
  c_dig_message: cover property ((s.dig == DIG_LOW) ##[1:50] dig_raise);
  c_diag_enter: cover property ($rose(diag_mode_o));
  c_irq_out: cover property ($rose(irq_o) ##[1:50] $fell(irq_o));

endmodule

// >>> bench/cascade_pic_model.sv
// Behavioural model of the cascaded master and slave interrupt controller pair
`timescale 1ns/1ps
module cascade_pic_model (
  input  wire logic       ir0_i,
  input  wire logic       ir1_i,
  input  wire logic [7:0] master_mask_i,
  input  wire logic [7:0] slave_mask_i,
  output logic      [7:0] request_reg_o,
  output logic            cpu_int_o
);
  logic cascade_req;

  // Request register reflects the raw request inputs, masked or not
  assign request_reg_o = {6'h00, ir1_i, ir0_i};
  // Slave output feeds master input 1; both mask bits must be low to pass
  assign cascade_req   = |(request_reg_o & ~slave_mask_i);
  assign cpu_int_o     = cascade_req & ~master_mask_i[1];
endmodule

// >>> bench/mmu_display_digitizer_irq_test.sv
// Self-checking testbench for the display and digitizer interrupt block
`timescale 1ns/1ps
module mmu_display_digitizer_irq_test;
  logic        clock_i = 1'b0;
  logic        rst_i   = 1'b1;
  logic [4:0]  address_i = 5'h00;
  logic        read_i = 1'b0;
  logic        write_i = 1'b0;
  logic [31:0] writedata_i = 32'h0;
  logic [3:0]  byteenable_i = 4'hf;
  logic        send_new_strobe_n_i = 1'b1;
  logic        digitizer_request_n_i = 1'b1;
  logic        message_select_i = 1'b0;
  logic [7:0]  master_mask = 8'hff;
  logic [7:0]  slave_mask = 8'hff;
  logic [31:0] readdata_o, q;
  logic        waitrequest_o, slave_request_in0_o, slave_request_in1_o, diag_mode_o, irq_o;
  logic [7:0]  request_reg;
  logic        cpu_int;
  int          n_errors = 0;
  int          comparisons = 0;
  int          cycles = 0;

  typedef struct {logic [4:0] a; logic [31:0] d; logic [31:0] e;} row_t;
  row_t rows[4] = '{'{5'h00, 32'h0200, 32'h0200}, '{5'h10, 32'h3, 32'h3},
                    '{5'h08, 32'h55, 32'h55}, '{5'h14, 32'hffffffff, 32'h0}};

  always #5 clock_i = ~clock_i;

  mmu_display_digitizer_irq u_mmu_display_digitizer_irq (
    .clock_i(clock_i), .rst_i(rst_i), .address_i(address_i), .read_i(read_i),
    .write_i(write_i), .writedata_i(writedata_i), .byteenable_i(byteenable_i),
    .readdata_o(readdata_o), .waitrequest_o(waitrequest_o),
    .send_new_strobe_n_i(send_new_strobe_n_i), .digitizer_request_n_i(digitizer_request_n_i),
    .message_select_i(message_select_i), .slave_request_in0_o(slave_request_in0_o),
    .slave_request_in1_o(slave_request_in1_o), .diag_mode_o(diag_mode_o), .irq_o(irq_o));

  cascade_pic_model u_cascade_pic_model (
    .ir0_i(slave_request_in0_o), .ir1_i(slave_request_in1_o), .master_mask_i(master_mask),
    .slave_mask_i(slave_mask), .request_reg_o(request_reg), .cpu_int_o(cpu_int));

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("counts: %0d comparisons, %0d mismatches", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Request is held until waitrequest is sampled low; data taken at that edge.
  // Only the cycle ceiling below ends a wait that never gets an answer.
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
                     output logic [31:0] rd);
    @(posedge clock_i);
    write_i     <= wr;
    read_i      <= ~wr;
    address_i   <= a;
    writedata_i <= d;
    do begin
      @(posedge clock_i);
    end while (waitrequest_o !== 1'b0);
    rd = readdata_o;
    write_i <= 1'b0;
    read_i  <= 1'b0;
  endtask

  task automatic wcyc(input int n);
    repeat (n) @(posedge clock_i);
  endtask

  // Pin levels are held seven cycles, more than three times the two the filter needs
  task automatic pin(input logic sn, input logic dr, input logic ms);
    @(posedge clock_i);
    send_new_strobe_n_i   <= sn;
    digitizer_request_n_i <= dr;
    message_select_i      <= ms;
    wcyc(6);
  endtask

  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      complete_run();
    end
  end

  initial begin
    // ---------------------------------------------------------------
    // Reset
    // ---------------------------------------------------------------
    wcyc(4);
    chk("wait_in_reset", waitrequest_o, 1'b1);
    chk("outs_in_reset", {slave_request_in0_o, slave_request_in1_o, diag_mode_o, irq_o}, 4'h0);
    rst_i <= 1'b0;
    wcyc(1);
    chk("ir_lines_idle", request_reg, 8'h00);
    $display("test reset done");
    // ---------------------------------------------------------------
    // Register table
    // ---------------------------------------------------------------
    foreach (rows[i]) begin
      bus(1'b1, rows[i].a, rows[i].d, q);
      bus(1'b0, rows[i].a, 32'h0, q);
      chk("reg_readback", q, rows[i].e);
    end
    $display("test registers done");
    // ---------------------------------------------------------------
    // Diagnostic entry
    // ---------------------------------------------------------------
    bus(1'b1, mmu_irq_pkg::OFF_DIAG_A, 32'(mmu_irq_pkg::DIAG_A_ENTER), q);
    bus(1'b1, mmu_irq_pkg::OFF_STATUS_MODE, 32'(mmu_irq_pkg::SMR_DIAG_KEY), q);
    bus(1'b1, mmu_irq_pkg::OFF_DIAG_B, 32'(mmu_irq_pkg::DIAG_B_ENTER), q);
    wcyc(2);
    chk("diag_mode", diag_mode_o, 1'b1);
    bus(1'b0, mmu_irq_pkg::OFF_IRQ_STATUS, 32'h0, q);
    chk("status_diag", q, 32'h4);
    $display("test diag entry done");
    // ---------------------------------------------------------------
    // Display request: refused while disabled, then raised and cleared
    // ---------------------------------------------------------------
    bus(1'b1, mmu_irq_pkg::OFF_STATUS_MODE, 32'h0, q);
    pin(1'b0, 1'b1, 1'b0);
    pin(1'b1, 1'b1, 1'b0);
    wcyc(4);
    chk("disp_refused", slave_request_in0_o, 1'b0);
    bus(1'b1, mmu_irq_pkg::OFF_STATUS_MODE, 32'h0200, q);
    master_mask <= 8'hfd;
    slave_mask  <= 8'hfc;
    pin(1'b0, 1'b1, 1'b0);
    pin(1'b1, 1'b1, 1'b0);
    wcyc(4);
    chk("disp_raised", slave_request_in0_o, 1'b1);
    chk("slave_ir0", request_reg, 8'h01);
    chk("cpu_int", cpu_int, 1'b1);
    chk("irq_disp", irq_o, 1'b1);
    master_mask <= 8'hff;
    wcyc(20);
    chk("disp_held", slave_request_in0_o, 1'b1);
    chk("cpu_masked", cpu_int, 1'b0);
    bus(1'b0, mmu_irq_pkg::OFF_STATUS_MODE, 32'h0, q);
    chk("smr_pending", q, 32'h0208);
    bus(1'b1, mmu_irq_pkg::OFF_STATUS_MODE, 32'h0208, q);
    wcyc(2);
    chk("disp_cleared", slave_request_in0_o, 1'b0);
    chk("ir0_low", request_reg[0], 1'b0);
    bus(1'b0, mmu_irq_pkg::OFF_IRQ_STATUS, 32'h0, q);
    chk("status_disp", q, 32'h1);
    wcyc(2);
    chk("irq_cleared", irq_o, 1'b0);
    $display("test display done");
    // ---------------------------------------------------------------
    // Digitizer message: masked, then unmasked, then cleared
    // ---------------------------------------------------------------
    bus(1'b1, mmu_irq_pkg::OFF_IRQ_MASK, 32'h0, q);
    pin(1'b1, 1'b1, 1'b1);
    pin(1'b1, 1'b0, 1'b1);
    pin(1'b1, 1'b1, 1'b1);
    wcyc(4);
    chk("dig_early", slave_request_in1_o, 1'b0);
    pin(1'b1, 1'b1, 1'b0);
    wcyc(4);
    chk("dig_raised", slave_request_in1_o, 1'b1);
    chk("slave_ir1", request_reg, 8'h02);
    chk("irq_masked", irq_o, 1'b0);
    bus(1'b1, mmu_irq_pkg::OFF_IRQ_MASK, 32'h3, q);
    wcyc(2);
    chk("irq_unmasked", irq_o, 1'b1);
    wcyc(10);
    chk("dig_held", slave_request_in1_o, 1'b1);
    bus(1'b1, mmu_irq_pkg::OFF_STATUS_MODE, 32'h0010, q);
    wcyc(2);
    chk("dig_cleared", slave_request_in1_o, 1'b0);
    chk("ir1_low", request_reg[1], 1'b0);
    $display("test digitizer done");
    // ---------------------------------------------------------------
    // Diagnostic exit
    // ---------------------------------------------------------------
    bus(1'b1, mmu_irq_pkg::OFF_DIAG_B, 32'(mmu_irq_pkg::DIAG_B_LEAVE), q);
    bus(1'b1, mmu_irq_pkg::OFF_STATUS_MODE, 32'(mmu_irq_pkg::SMR_DIAG_KEY), q);
    wcyc(2);
    chk("diag_left", diag_mode_o, 1'b0);
    $display("test diag exit done");
    // ---------------------------------------------------------------
    // Reset in mid-run with a request pending
    // ---------------------------------------------------------------
    bus(1'b1, mmu_irq_pkg::OFF_STATUS_MODE, 32'h0200, q);
    pin(1'b0, 1'b1, 1'b0);
    pin(1'b1, 1'b1, 1'b0);
    wcyc(4);
    chk("disp_again", slave_request_in0_o, 1'b1);
    rst_i <= 1'b1;
    wcyc(4);
    chk("outs_mid_reset", {slave_request_in0_o, slave_request_in1_o, diag_mode_o, irq_o}, 4'h0);
    rst_i <= 1'b0;
    wcyc(1);
    chk("wait_after_reset", waitrequest_o, 1'b1);
    chk("ir_idle_after_reset", request_reg, 8'h00);
    bus(1'b0, mmu_irq_pkg::OFF_STATUS_MODE, 32'h0, q);
    chk("smr_after_reset", q, 32'h0);
    $display("test mid-run reset done");
    complete_run();
  end
endmodule
